/* verilog/cesi_cfg.svh */
`ifndef CESI_CFG_SVH
`define CESI_CFG_SVH
`define CESI_OFF_MASK   8'h28
`define CESI_OFF_ERR    8'h2C
`define CESI_OFF_CTRL   8'h3C
`define CESI_MASK_RST   32'h0000_0000
`define CESI_WARN_LIMIT 8'h60
`define CESI_B_OVR      21
`define CESI_B_ERR_HI   15
`define CESI_B_ERR_LO   10
`define CESI_B_TWARN    9
`define CESI_B_RWARN    8
`define CESI_B_IDLE     7
`define CESI_B_TX       6
`define CESI_B_FC_HI    5
`define CESI_B_FC_LO    4
`define CESI_B_RX       3
`define CESI_B_BOFF     2
`define CESI_B_SUM      1
`define CESI_C_SOFT_RESET_BIT    0
`define CESI_C_MON      1
`define CESI_C_FIFO     2
`define CESI_C_PN       3
`define CESI_FIFO_LO    5
`define CESI_FIFO_HI    7
`define CESI_FC_ACTIVE  2'h0
`define CESI_FC_PASSIVE 2'h1
`define CESI_BIT_TIME_NS 1000
`define CESI_CLK_MHZ     25
`define CESI_BIT_CYCLES ((`CESI_BIT_TIME_NS * `CESI_CLK_MHZ) / 1000)
`endif

/* verilog/cesi_pkg.sv */
package cesi_pkg;
    typedef struct packed {
        logic [7:0] rx_err_cnt;
        logic [7:0] tx_err_cnt;
        logic       bus_idle;
        logic       transmitting;
        logic       receiving;
        logic [1:0] fault;
    } cesi_engine_t;

    typedef struct packed {
        logic [31:0] mbox;
        logic [2:0]  fifo;
    } cesi_events_t;

    typedef enum logic [2:0] {
        CESI_NORMAL = 3'h1,
        CESI_CLEAR  = 3'h2,
        CESI_MONPAS = 3'h4
    } cesi_fc_state_t;
endpackage

/* verilog/cesi_bit_timer.sv */
`timescale 1ns/1ps
`include "cesi_cfg.svh"
module cesi_bit_timer
    import cesi_pkg::*;
#(
    parameter int CYCLES = `CESI_BIT_CYCLES
) (
    input  wire logic clk_i,   // clock
    input  wire logic rst_i,   // sync reset
    input  wire logic start_i, // load one bit time
    output logic      done_o   // pulse at end of bit time
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES);

    generate
        if (CYCLES < 1)
        begin : g_chk
            $error("bit time must be at least one cycle");
        end
    endgenerate

    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    logic         done_q;
    logic         done_d;

    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start_i)
            cnt_d = LOAD;
        else if (cnt_q != '0)
        begin
            cnt_d  = cnt_q - 1'b1;
            done_d = (cnt_q == W'(1));
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cnt_q  <= '0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign done_o = done_q;
endmodule // cesi_bit_timer

/* verilog/cesi_irq_gate.sv */
`timescale 1ns/1ps
`include "cesi_cfg.svh"
module cesi_irq_gate
    import cesi_pkg::*;
(
    input  wire logic         clk_i,     // clock
    input  wire logic         rst_i,     // sync reset
    input  wire logic         fifo_en_i, // rx fifo enabled
    input  wire logic [31:0]  mask_i,    // enable mask
    input  cesi_events_t      events_i,  // event flags
    output logic              irq_o      // message irq request
);
    logic [31:0] hit;
    logic        irq_q;
    logic        irq_d;

    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_bit
            if (i >= `CESI_FIFO_LO && i <= `CESI_FIFO_HI)
            begin : g_fifo
                // fifo events borrow bits 5..7 when the fifo is on
                assign hit[i] = mask_i[i] & (fifo_en_i ?
                    events_i.fifo[i-`CESI_FIFO_LO] :
                    events_i.mbox[i]);
            end
            else
            begin : g_mbox
                assign hit[i] = mask_i[i] & events_i.mbox[i];
            end
        end
    endgenerate

    always_comb
    begin
        irq_d = |hit;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            irq_q <= 1'b0;
        else
            irq_q <= irq_d;
    end

    assign irq_o = irq_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_gate_block;
        !(|(mask_i & events_i.mbox)) && !fifo_en_i |=> !irq_o;
    endproperty
    a_gate_block: assert property (p_gate_block)
        else $error("irq raised with no enabled event");

    property p_fifo_bit;
        fifo_en_i && events_i.fifo[0] && mask_i[`CESI_FIFO_LO] |=> irq_o;
    endproperty
    a_fifo_bit: assert property (p_fifo_bit)
        else $error("fifo event on enabled bit did not raise irq");

    property p_mbox_bit;
        !fifo_en_i && |(events_i.mbox & mask_i) |=> irq_o;
    endproperty
    a_mbox_bit: assert property (p_mbox_bit)
        else $error("enabled mailbox event did not raise irq");
endmodule // cesi_irq_gate

/* verilog/cesi_top.sv */
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "cesi_cfg.svh"
module cesi_top
    import cesi_pkg::*;
#(
    parameter int BIT_CYCLES = `CESI_BIT_CYCLES
) (
    input  wire logic        clk_i,   // 25 MHz clock
    input  wire logic        rst_i,   // sync reset, high
    input  wire logic        cyc_i,   // wishbone cycle
    input  wire logic        stb_i,   // wishbone strobe
    input  wire logic        we_i,    // wishbone write
    input  wire logic [7:0]  adr_i,   // byte address
    input  wire logic [3:0]  sel_i,   // byte selects
    input  wire logic [31:0] dat_i,   // write data
    output logic      [31:0] dat_o,   // read data
    output logic             ack_o,   // wishbone ack
    input  cesi_engine_t     eng_i,   // frame engine state
    input  wire logic [5:0]  err_evt_i, // error pulses 15..10
    input  cesi_events_t     evt_i,   // mailbox/fifo flags
    output logic             soft_reset_o,   // soft reset bit
    output logic             fifo_enable_o,  // rx fifo enable
    output logic             msg_irq_o       // message irq
);
    localparam int BIT_WAIT = BIT_CYCLES + 2;

    generate
        if (BIT_CYCLES < 1 || BIT_CYCLES > 4096)
        begin : g_chk
            $error("BIT_CYCLES out of range");
        end
    endgenerate

    // bus state
    logic        ack_q;
    logic        ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [31:0] mask_q;
    logic [31:0] mask_d;
    logic [3:0]  ctrl_q;
    logic [3:0]  ctrl_d;

    // error and status flags
    logic [5:0]  err_q;
    logic [5:0]  err_d;
    logic        ovr_q;
    logic        ovr_d;
    logic        boff_q;
    logic        boff_d;
    logic        rwarn_q;
    logic        rwarn_d;
    logic        twarn_q;
    logic        twarn_d;

    // fault confinement sequencing
    cesi_fc_state_t st_q;
    cesi_fc_state_t st_d;
    logic [1:0]     fc_code;
    logic           mon_req;
    logic           tmr_start;
    logic           tmr_done;

    logic        req;
    logic        rd;
    logic        wr;
    logic        hit_mask;
    logic        hit_err;
    logic        hit_ctrl;
    logic [31:0] err_word;

    assign req      = cyc_i & stb_i & ~ack_q;
    assign rd       = req & ~we_i;
    assign wr       = req & we_i;
    assign hit_mask = (adr_i == `CESI_OFF_MASK);
    assign hit_err  = (adr_i == `CESI_OFF_ERR);
    assign hit_ctrl = (adr_i == `CESI_OFF_CTRL);
    assign mon_req  = ctrl_q[`CESI_C_SOFT_RESET_BIT] & ctrl_q[`CESI_C_MON];

    always_comb
    begin
        st_d      = st_q;
        tmr_start = 1'b0;
        fc_code   = eng_i.fault;
        case (st_q)
            CESI_NORMAL:
            begin
                if (mon_req)
                begin
                    st_d      = CESI_CLEAR;
                    tmr_start = 1'b1;
                end
            end
            CESI_CLEAR:
            begin
                fc_code = `CESI_FC_ACTIVE;
                if (!mon_req)
                    st_d = CESI_NORMAL;
                else if (tmr_done)
                    st_d = CESI_MONPAS;
            end
            CESI_MONPAS:
            begin
                fc_code = `CESI_FC_PASSIVE;
                if (!mon_req)
                    st_d = CESI_NORMAL;
            end
            default:
            begin
                st_d = CESI_NORMAL;
            end
        endcase
    end

    cesi_bit_timer #(
        .CYCLES (BIT_CYCLES)
    ) u_bit_timer (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (tmr_start),
        .done_o  (tmr_done)
    );

    always_comb
    begin
        err_word                = '0; // bit 0 and reserved read zero
        err_word[`CESI_B_OVR]   = ovr_q;
        err_word[`CESI_B_ERR_HI:`CESI_B_ERR_LO] = err_q;
        err_word[`CESI_B_TWARN] = twarn_q;
        err_word[`CESI_B_RWARN] = rwarn_q;
        err_word[`CESI_B_IDLE]  = eng_i.bus_idle;
        err_word[`CESI_B_TX]    = eng_i.transmitting;
        err_word[`CESI_B_FC_HI:`CESI_B_FC_LO] = fc_code;
        err_word[`CESI_B_RX]    = eng_i.receiving;
        err_word[`CESI_B_BOFF]  = boff_q;
        err_word[`CESI_B_SUM]   = |err_q;
    end

    always_comb
    begin
        ack_d  = req;
        rdat_d = '0;
        mask_d = mask_q;
        ctrl_d = ctrl_q;
        if (rd && hit_mask)
            rdat_d = mask_q;
        if (rd && hit_err)
            rdat_d = err_word;
        if (rd && hit_ctrl)
            rdat_d = {28'h000_0000, ctrl_q};
        // partial writes to the mask are dropped
        if (wr && hit_mask && sel_i == 4'hF)
            mask_d = dat_i;
        if (wr && hit_ctrl && sel_i[0])
            ctrl_d = dat_i[3:0];
    end

    always_comb
    begin
        err_d   = err_q;
        ovr_d   = ovr_q;
        boff_d  = boff_q;
        rwarn_d = rwarn_q;
        // error flags clear on read; a new error wins over it
        if (rd && hit_err)
            err_d = '0;
        err_d = err_d | err_evt_i;
        if (wr && hit_err && sel_i[2] && dat_i[`CESI_B_OVR])
            ovr_d = 1'b0;
        if ((|err_evt_i) && (|err_q))
            ovr_d = 1'b1;
        if (wr && hit_err && sel_i[0] && dat_i[`CESI_B_BOFF])
            boff_d = 1'b0;
        if (fc_code[1])
            boff_d = 1'b1;
        // frozen in low power, refreshed as soon as it is left
        if (!ctrl_q[`CESI_C_PN])
            rwarn_d = (eng_i.rx_err_cnt >= `CESI_WARN_LIMIT);
        twarn_d = (eng_i.tx_err_cnt >= `CESI_WARN_LIMIT);
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q   <= 1'b0;
            rdat_q  <= '0;
            mask_q  <= `CESI_MASK_RST;
            ctrl_q  <= '0;
            err_q   <= '0;
            ovr_q   <= 1'b0;
            boff_q  <= 1'b0;
            rwarn_q <= 1'b0;
            twarn_q <= 1'b0;
            st_q    <= CESI_NORMAL;
        end
        else
        begin
            ack_q   <= ack_d;
            rdat_q  <= rdat_d;
            mask_q  <= mask_d;
            ctrl_q  <= ctrl_d;
            err_q   <= err_d;
            ovr_q   <= ovr_d;
            boff_q  <= boff_d;
            rwarn_q <= rwarn_d;
            twarn_q <= twarn_d;
            st_q    <= st_d;
        end
    end

    cesi_irq_gate u_irq_gate (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .fifo_en_i (ctrl_q[`CESI_C_FIFO]),
        .mask_i    (mask_q),
        .events_i  (evt_i),
        .irq_o     (msg_irq_o)
    );

    assign dat_o         = rdat_q;
    assign ack_o         = ack_q;
    assign soft_reset_o  = ctrl_q[`CESI_C_SOFT_RESET_BIT];
    assign fifo_enable_o = ctrl_q[`CESI_C_FIFO];

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_rx_warn;
        !ctrl_q[`CESI_C_PN] |=>
            rwarn_q == ($past(eng_i.rx_err_cnt) >= `CESI_WARN_LIMIT);
    endproperty
    a_rx_warn: assert property (p_rx_warn)
        else $error("rx warning does not follow receive count");

    property p_rx_hold;
        ctrl_q[`CESI_C_PN] |=> $stable(rwarn_q);
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx warning changed inside low power mode");

    property p_tx_warn;
        eng_i.tx_err_cnt >= `CESI_WARN_LIMIT |=> twarn_q;
    endproperty
    a_tx_warn: assert property (p_tx_warn)
        else $error("tx warning missing at count 96 or more");

    property p_state_read;
        rd && hit_err |=> dat_o[`CESI_B_IDLE] == $past(eng_i.bus_idle)
            && dat_o[`CESI_B_TX] == $past(eng_i.transmitting)
            && dat_o[`CESI_B_RX] == $past(eng_i.receiving)
            && dat_o[0] == 1'b0;
    endproperty
    a_state_read: assert property (p_state_read)
        else $error("state bits read back wrong");

    property p_bus_off;
        st_q == CESI_NORMAL && eng_i.fault[1] |=> boff_q;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("bus off flag not set in bus off");

    property p_mon_seq;
        st_q == CESI_NORMAL && mon_req |=>
            fc_code == `CESI_FC_ACTIVE ##[1:BIT_WAIT]
            (st_q != CESI_CLEAR);
    endproperty
    a_mon_seq: assert property (p_mon_seq)
        else $error("monitor entry sequence wrong");

    property p_mon_pass;
        st_q == CESI_MONPAS |-> fc_code == `CESI_FC_PASSIVE
            && $past(st_q) != CESI_NORMAL;
    endproperty
    a_mon_pass: assert property (p_mon_pass)
        else $error("monitor code not 01 after clear");

    property p_summary;
        rd && hit_err |=> dat_o[`CESI_B_SUM] == $past(|err_q);
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary flag is not the OR of error flags");

    property p_overrun;
        (|err_evt_i) && (|err_q) |=> ovr_q;
    endproperty
    a_overrun: assert property (p_overrun)
        else $error("overrun not set on repeated error");

    property p_mask_full;
        wr && hit_mask && sel_i != 4'hF |=> $stable(mask_q);
    endproperty
    a_mask_full: assert property (p_mask_full)
        else $error("partial write altered the enable mask");

    c_mon_pass: cover property (st_q == CESI_CLEAR ##1
        st_q == CESI_MONPAS);
    c_rx_warn: cover property ($rose(rwarn_q));
    c_overrun: cover property ($rose(ovr_q));
    c_irq: cover property ($rose(msg_irq_o));
endmodule // cesi_top

/* tb/cesi_engine_model.sv */
`timescale 1ns/1ps
module cesi_engine_model
    import cesi_pkg::*;
(
    input  wire logic        clk_i,     // clock
    input  wire logic        rst_i,     // sync reset
    input  cesi_engine_t     eng_cmd_i, // wanted engine state
    input  wire logic [5:0]  err_cmd_i, // error request levels
    input  cesi_events_t     evt_cmd_i, // wanted event flags
    output cesi_engine_t     eng_o,     // engine state to block
    output logic      [5:0]  err_o,     // one-cycle error pulses
    output cesi_events_t     evt_o      // event flags to block
);
    logic [5:0] err_last_q;

    // each new error request gives exactly one pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            eng_o      <= '0;
            err_o      <= 6'h00;
            err_last_q <= 6'h00;
            evt_o      <= '0;
        end
        else
        begin
            eng_o      <= eng_cmd_i;
            err_o      <= err_cmd_i & ~err_last_q;
            err_last_q <= err_cmd_i;
            evt_o      <= evt_cmd_i;
        end
    end
endmodule // cesi_engine_model

/* tb/cesi_top_tb.sv */
`timescale 1ns/1ps
`include "cesi_cfg.svh"
module cesi_top_tb;
    import cesi_pkg::*;
    localparam int BITC = 4;
    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    logic         cyc = 1'b0;
    logic         stb = 1'b0;
    logic         we = 1'b0;
    logic [7:0]   adr = 8'h00;
    logic [3:0]   sel = 4'h0;
    logic [31:0]  wdat = 32'h0000_0000;
    logic [31:0]  dat_o;
    logic [31:0]  rd;
    logic         ack_o;
    logic         msg_irq_o;
    logic         swr;
    logic         fen;
    logic [5:0]   err_cmd = 6'h00;
    logic [5:0]   err;
    cesi_engine_t eng_cmd = '0;
    cesi_engine_t eng;
    cesi_events_t evt_cmd = '0;
    cesi_events_t evt;
    int           miscompares = 0;
    int           check_count = 0;

    initial forever #20 clk_i = ~clk_i;

    cesi_top #(.BIT_CYCLES(BITC)) u_cesi_top (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .eng_i(eng), .err_evt_i(err),
        .evt_i(evt), .soft_reset_o(swr), .fifo_enable_o(fen),
        .msg_irq_o(msg_irq_o));

    cesi_engine_model u_cesi_engine_model (
        .clk_i(clk_i), .rst_i(rst_i), .eng_cmd_i(eng_cmd),
        .err_cmd_i(err_cmd), .evt_cmd_i(evt_cmd), .eng_o(eng),
        .err_o(err), .evt_o(evt));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // full-word transfers only, a missing ack after 50 cycles counts as a mismatch
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= 4'hF;
        wdat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (ack_o !== 1'b1 && n < 50);
        rd = dat_o;
        if (n >= 50)
            chk(32'h0000_0000, 32'h0000_0001);
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                         input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000);
        chk(rd & m, exp);
    endtask

    task automatic st(input logic [4:0] s, input logic [31:0] exp);
        {eng_cmd.bus_idle, eng_cmd.transmitting, eng_cmd.receiving,
         eng_cmd.fault} <= s;
        repeat (4) @(posedge clk_i);
        rdchk(`CESI_OFF_ERR, 32'h0000_00FC, exp);
    endtask

    task automatic irq(input logic [31:0] m, input logic [31:0] mb,
                       input logic [2:0] f, input logic exp);
        wb(1'b1, `CESI_OFF_MASK, m);
        evt_cmd.mbox <= mb;
        evt_cmd.fifo <= f;
        repeat (4) @(posedge clk_i);
        chk({31'h0, msg_irq_o}, {31'h0, exp});
    endtask

    task automatic t_reset;
        rdchk(`CESI_OFF_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk(8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
        rdchk(`CESI_OFF_ERR, 32'h0000_0001, 32'h0000_0000);
        $display("test reset done");
    endtask

    task automatic t_warn;
        for (int i = 0; i < 2; i++)
        begin
            eng_cmd.rx_err_cnt <= 8'(95 + i);
            eng_cmd.tx_err_cnt <= 8'(96 - i);
            repeat (4) @(posedge clk_i);
            rdchk(`CESI_OFF_ERR, 32'h300, i ? 32'h100 : 32'h200);
        end
        eng_cmd.rx_err_cnt <= 8'h00;
        wb(1'b1, `CESI_OFF_CTRL, 32'h8);
        eng_cmd.rx_err_cnt <= 8'h64;
        repeat (4) @(posedge clk_i);
        rdchk(`CESI_OFF_ERR, 32'h100, 32'h000);
        wb(1'b1, `CESI_OFF_CTRL, 32'h0);
        repeat (2) @(posedge clk_i);
        rdchk(`CESI_OFF_ERR, 32'h100, 32'h100);
        $display("test warning done");
    endtask

    task automatic t_state;
        st(5'b10000, 32'h80);
        st(5'b01001, 32'h50);
        st(5'b00110, 32'h2C);
        st(5'b00011, 32'h34);
        st(5'b00000, 32'h04);
        wb(1'b1, `CESI_OFF_ERR, 32'h0000_0004);
        rdchk(`CESI_OFF_ERR, 32'h0000_0004, 32'h0);
        $display("test state done");
    endtask

    task automatic t_err;
        err_cmd <= 6'h20;
        repeat (4) @(posedge clk_i);
        err_cmd <= 6'h00;
        rdchk(`CESI_OFF_ERR, 32'h0020_FC02, 32'h0000_8002);
        rdchk(`CESI_OFF_ERR, 32'h0020_FC02, 32'h0);
        for (int i = 0; i < 2; i++)
        begin
            err_cmd <= 6'h01;
            repeat (2) @(posedge clk_i);
            err_cmd <= 6'h00;
            repeat (2) @(posedge clk_i);
        end
        rdchk(`CESI_OFF_ERR, 32'h0020_FC02, 32'h0020_0402);
        wb(1'b1, `CESI_OFF_ERR, 32'h0020_0000);
        rdchk(`CESI_OFF_ERR, 32'h0020_FC02, 32'h0);
        $display("test errors done");
    endtask

    task automatic t_monitor;
        // engine reports passive, so a 00 read shows the forced clear
        eng_cmd.fault <= 2'b01;
        wb(1'b1, `CESI_OFF_CTRL, 32'h3);
        chk({31'h0, swr}, 32'h0000_0001);
        rdchk(`CESI_OFF_ERR, 32'h30, 32'h00);
        // engine reports active, so a 01 read shows the monitor code
        eng_cmd.fault <= 2'b00;
        rdchk(`CESI_OFF_CTRL, 32'hF, 32'h3);
        repeat (BITC + 6) @(posedge clk_i);
        rdchk(`CESI_OFF_ERR, 32'h30, 32'h10);
        wb(1'b1, `CESI_OFF_CTRL, 32'h0);
        chk({31'h0, swr}, 32'h0000_0000);
        rdchk(`CESI_OFF_ERR, 32'h30, 32'h00);
        $display("test monitor done");
    endtask

    task automatic t_irq;
        irq(32'h0000_0008, 32'h0000_0008, 3'h0, 1'b1);
        irq(32'h0000_0000, 32'h0000_0008, 3'h0, 1'b0);
        irq(32'h8000_0000, 32'h8000_0000, 3'h0, 1'b1);
        irq(32'h7FFF_FFFF, 32'h8000_0000, 3'h7, 1'b0);
        wb(1'b1, `CESI_OFF_CTRL, 32'h4);
        chk({31'h0, fen}, 32'h0000_0001);
        irq(32'h0000_0040, 32'h0000_0040, 3'h0, 1'b0);
        irq(32'h0000_0040, 32'h0000_0000, 3'h2, 1'b1);
        irq(32'h0000_00A0, 32'h0000_0000, 3'h5, 1'b1);
        irq(32'h0000_0100, 32'h0000_0100, 3'h0, 1'b1);
        rdchk(`CESI_OFF_MASK, 32'hFFFF_FFFF, 32'h0000_0100);
        wb(1'b1, `CESI_OFF_CTRL, 32'h0);
        chk({31'h0, fen}, 32'h0000_0000);
        $display("test irq done");
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_warn();
        t_state();
        t_err();
        t_monitor();
        t_irq();
        conclude();
    end

    initial
    begin
        repeat (5000) @(posedge clk_i);
        miscompares++;
        conclude();
    end
endmodule // cesi_top_tb
